// >>> bench/cpu_core_model.sv
// CPU core model issuing store and load program-memory instructions
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic clk_i,
  input wire logic [7:0] load_data_i,
  input wire logic load_valid_i,
  output logic store_strobe_o,
  output logic load_strobe_o,
  output logic [15:0] pointer_o,
  output logic [15:0] data_pair_o,
  output logic [15:0] flash_word_o
);
  ////////////////////////////////////////////////////////////////////////
  // Array stand-in: word contents follow the word address
  assign flash_word_o = {pointer_o[8:1], ~pointer_o[8:1]};
  // Idle levels at time zero
  initial begin
    store_strobe_o = 1'b0;
    load_strobe_o = 1'b0;
    pointer_o = 16'h0000;
    data_pair_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // One instruction pulse; the load result is taken a cycle later
  task automatic issue(input logic ld, input logic [15:0] ptr,
                       output logic [7:0] got, output logic vld);
    pointer_o <= ptr;
    data_pair_o <= ~ptr;
    if (ld) begin
      load_strobe_o <= 1'b1;
    end else begin
      store_strobe_o <= 1'b1;
    end
    @(posedge clk_i);
    load_strobe_o <= 1'b0;
    store_strobe_o <= 1'b0;
    @(posedge clk_i);
    got = load_data_i;
    vld = load_valid_i;
  endtask
endmodule // cpu_core_model

// >>> bench/self_program_flash_control_tb.sv
// Self-checking bench for the self-programming flash control unit
`timescale 1ns/1ps
module self_program_flash_control_tb;
  localparam int PROG = 20; // Shortened program time
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic store_strobe_i, load_strobe_i, load_valid_o, cpu_stall_o;
  logic [15:0] pointer_i, data_pair_i, flash_word_i;
  logic [7:0] load_data_o, q, got;
  logic flash_erase_o, flash_write_o, eeprom_write_busy_i, vld;
  logic [6:0] flash_page_o;
  logic [7:0] fuse_low_byte_i, fuse_high_byte_i, fuse_extended_byte_i;
  logic [7:0] lock_bits_i;
  int n_fail, num_checks, cycles, pulses, stall_len;
  // Expected signature row, pointers 0..7 (reserved read 0xff)
  logic [7:0] sig_row [8] = '{8'h5a, 8'hc3, 8'ha5, 8'hff,
                              8'h3c, 8'h07, 8'hff, 8'h70};
  ////////////////////////////////////////////////////////////////////////
  // Device and CPU model
  self_program_flash_control #(.PROG_CYCLES(PROG), .SIG_BYTE0(8'h5a),
    .SIG_BYTE1(8'ha5), .SIG_BYTE2(8'h3c), .OSC_CAL(8'hc3),
    .TS_OFFSET(8'h07), .TS_GAIN(8'h70)) i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .store_strobe_i, .load_strobe_i,
    .pointer_i, .data_pair_i, .flash_word_i, .load_data_o, .load_valid_o,
    .cpu_stall_o, .flash_erase_o, .flash_write_o, .flash_page_o,
    .eeprom_write_busy_i, .fuse_low_byte_i, .fuse_high_byte_i,
    .fuse_extended_byte_i, .lock_bits_i);
  cpu_core_model i_cpu (.clk_i, .load_data_i(load_data_o),
    .load_valid_i(load_valid_o), .store_strobe_o(store_strobe_i),
    .load_strobe_o(load_strobe_i), .pointer_o(pointer_i),
    .data_pair_o(data_pair_i), .flash_word_o(flash_word_i));
  ////////////////////////////////////////////////////////////////////////
  // Clock, hang limit and program pulse monitors
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (flash_erase_o === 1'b1 || flash_write_o === 1'b1) pulses++;
    if (cpu_stall_o === 1'b1) stall_len++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Value compare
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Classic Wishbone single access; waits for ack
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [7:0] d, output logic [7:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic arm(input logic [7:0] d);
    logic [7:0] dummy;
    wb(1'b1, spm_ctrl_pkg::ADDR_CSR, d, dummy);
  endtask
  task automatic csr_is(input logic [7:0] exp);
    wb(1'b0, spm_ctrl_pkg::ADDR_CSR, 8'h00, q);
    chk("csr", {8'h0, exp}, {8'h0, q});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    csr_is(spm_ctrl_pkg::CSR_RESET);
    wb(1'b0, 4'h8, 8'h00, q);
    chk("unmapped", 16'h0, {8'h0, q});
    arm(8'hc1);
    wb(1'b0, spm_ctrl_pkg::ADDR_CSR, 8'h00, q);
    chk("csr top bits", 16'h0, {8'h0, q & 8'hc0});
    $display("done reset");
  endtask
  task automatic t_windows();
    logic [7:0] pat [4] = '{8'h07, 8'h0b, 8'h31, 8'h02};
    foreach (pat[i]) begin
      arm(pat[i]);
      csr_is(8'h00);
    end
    arm(spm_ctrl_pkg::CMD_FILL);
    repeat (6) @(posedge clk_i);
    csr_is(8'h00);
    arm(spm_ctrl_pkg::CMD_WRITE);
    repeat (6) @(posedge clk_i);
    csr_is(8'h00);
    arm(spm_ctrl_pkg::CMD_FILL);
    i_cpu.issue(1'b0, 16'h0042, got, vld);
    csr_is(8'h00);
    arm({2'b00, spm_ctrl_pkg::CMD_CLEAR});
    csr_is({2'b00, spm_ctrl_pkg::CMD_CLEAR});
    $display("done windows");
  endtask
  task automatic t_fuse();
    logic [7:0] exp [4];
    logic [7:0] msk [4] = '{8'hff, 8'h03, 8'h01, 8'hff};
    for (int s = 0; s < 2; s++) begin
      // Second pass with other fuse and lock levels
      if (s == 1) begin
        fuse_low_byte_i <= 8'h9d;
        fuse_high_byte_i <= 8'h26;
        fuse_extended_byte_i <= 8'h01;
        lock_bits_i <= 8'hfe;
      end
      @(posedge clk_i);
      exp = '{fuse_low_byte_i, lock_bits_i, fuse_extended_byte_i,
              fuse_high_byte_i};
      for (int p = 0; p < 4; p++) begin
        arm(spm_ctrl_pkg::CMD_FUSE);
        i_cpu.issue(1'b1, 16'(p), got, vld);
        got = got & msk[p];
        exp[p] = exp[p] & msk[p];
        chk("fuse valid", 16'h1, {15'h0, vld});
        chk("fuse byte", {8'h0, exp[p]}, {8'h0, got});
        csr_is(8'h00);
      end
    end
    $display("done fuse");
  endtask
  task automatic t_sig();
    for (int p = 0; p < 8; p++) begin
      arm(spm_ctrl_pkg::CMD_SIG);
      i_cpu.issue(1'b1, 16'(p), got, vld);
      chk("sig byte", {8'h0, sig_row[p]}, {8'h0, got});
    end
    csr_is(8'h00);
    arm(spm_ctrl_pkg::CMD_SIG);
    repeat (5) @(posedge clk_i);
    i_cpu.issue(1'b1, 16'h0123, got, vld);
    chk("flash hi", 16'h0091, {8'h0, got});
    i_cpu.issue(1'b1, 16'h0122, got, vld);
    chk("flash lo", 16'h006e, {8'h0, got});
    pulses = 0;
    arm(spm_ctrl_pkg::CMD_SIG);
    i_cpu.issue(1'b0, 16'h1a80, got, vld);
    repeat (3) @(posedge clk_i);
    chk("sig store", 16'h0, 16'(pulses));
    $display("done signature");
  endtask
  task automatic t_prog(input logic [7:0] cmd);
    wb(1'b0, spm_ctrl_pkg::ADDR_STATUS, 8'h00, q);
    chk("ee idle", 16'h0, {15'h0, q[1]});
    arm(cmd);
    stall_len = 0;
    i_cpu.issue(1'b0, 16'h1a80, got, vld);
    chk("write", {15'h0, cmd[2]}, {15'h0, flash_write_o});
    chk("erase", {15'h0, cmd[1]}, {15'h0, flash_erase_o});
    chk("page", 16'h0035, {9'h0, flash_page_o});
    chk("stall", 16'h1, {15'h0, cpu_stall_o});
    csr_is(cmd);
    for (int n = 0; n < 100 && cpu_stall_o === 1'b1; n++) @(posedge clk_i);
    #1;
    chk("stall len", 16'(PROG), 16'(stall_len));
    csr_is(8'h00);
    $display("done program %h", cmd);
  endtask
  task automatic t_eeprom();
    eeprom_write_busy_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pulses = 0;
    arm(spm_ctrl_pkg::CMD_FUSE);
    i_cpu.issue(1'b1, 16'h0000, got, vld);
    chk("ee fuse", 16'h00ff, {8'h0, got});
    arm(spm_ctrl_pkg::CMD_ERASE);
    i_cpu.issue(1'b0, 16'h1a80, got, vld);
    repeat (3) @(posedge clk_i);
    chk("ee erase", 16'h0, {cpu_stall_o, 15'(pulses)});
    eeprom_write_busy_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("done eeprom");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, eeprom_write_busy_i} = 4'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    fuse_low_byte_i = 8'h62;
    fuse_high_byte_i = 8'hd9;
    fuse_extended_byte_i = 8'hfe;
    lock_bits_i = 8'hfd;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_windows();
    t_fuse();
    t_sig();
    t_prog(spm_ctrl_pkg::CMD_ERASE);
    t_prog(spm_ctrl_pkg::CMD_WRITE);
    t_eeprom();
    conclude();
  end
endmodule // self_program_flash_control_tb

// >>> core/self_program_flash_control.sv
// Self-programming flash control unit with Wishbone register access
`timescale 1ns/1ps
module self_program_flash_control #(
  parameter int WORD_BITS = 6, // Word index bits within a page
  parameter int PAGE_BITS = 7, // Page index bits
  parameter int PROG_CYCLES = spm_ctrl_pkg::PROG_CYCLES,
  parameter logic [7:0] SIG_BYTE0 = 8'h11, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h22, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h33, // Arbitrary identity value
  parameter logic [7:0] OSC_CAL = 8'h80,
  parameter logic [7:0] TS_OFFSET = 8'h00,
  parameter logic [7:0] TS_GAIN = 8'h80
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // CPU core side
  input wire logic store_strobe_i,
  input wire logic load_strobe_i,
  input wire logic [15:0] pointer_i,
  input wire logic [15:0] data_pair_i,
  input wire logic [15:0] flash_word_i,
  output logic [7:0] load_data_o,
  output logic load_valid_o,
  output logic cpu_stall_o,
  // Flash array side
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [PAGE_BITS-1:0] flash_page_o,
  // Status from outside
  input wire logic eeprom_write_busy_i,
  input wire logic [7:0] fuse_low_byte_i,
  input wire logic [7:0] fuse_high_byte_i,
  input wire logic [7:0] fuse_extended_byte_i,
  input wire logic [7:0] lock_bits_i
);

  localparam int DEPTH = 1 << WORD_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [1:0] {IDLE, ARMED, BUSY} state_e;
  state_e state; // Sequencer state
  logic [5:0] cmd; // Armed command pattern
  logic [2:0] win; // Cycles since arming
  logic [31:0] busy_cnt; // Erase/write timer
  logic eeb_s1, eeb_s2; // EEPROM busy sync
  logic [15:0] buf_mem [DEPTH]; // Temporary page buffer
  logic [DEPTH-1:0] buf_valid; // Word loaded flags
  logic bus_req; // Bus access this cycle
  logic csr_wr; // Control register write
  logic cmd_ok; // Written pattern accepted
  logic [5:0] wr_cmd; // Written low six bits
  logic store_hit; // Store within window
  logic load_hit; // Load within window
  logic [7:0] csr_view; // Read view of control

  // Accepted pattern check
  function automatic logic legal_cmd(input logic [5:0] c);
    legal_cmd = (c == spm_ctrl_pkg::CMD_FILL) ||
                (c == spm_ctrl_pkg::CMD_ERASE) ||
                (c == spm_ctrl_pkg::CMD_WRITE) ||
                (c == spm_ctrl_pkg::CMD_FUSE) ||
                (c == spm_ctrl_pkg::CMD_CLEAR) ||
                (c == spm_ctrl_pkg::CMD_SIG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign csr_wr = bus_req && wb_we_i && wb_sel_i[0] &&
                  (wb_adr_i == spm_ctrl_pkg::ADDR_CSR);
  assign wr_cmd = wb_dat_i[5:0];
  // Blocked while EEPROM writes
  assign cmd_ok = legal_cmd(wr_cmd) && !eeb_s2;
  // Windows count from cycle after the write
  assign store_hit = (state == ARMED) && store_strobe_i &&
                     (win < spm_ctrl_pkg::STORE_WINDOW);
  assign load_hit = (state == ARMED) && load_strobe_i &&
                    (win < spm_ctrl_pkg::LOAD_WINDOW);
  // Top bits always read zero
  assign csr_view = {2'b00, cmd};

  ////////////////////////////////////////////////////////////////////////////
  // EEPROM busy synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eeb_s1 <= 1'b0;
      eeb_s2 <= 1'b0;
    end else begin
      eeb_s1 <= eeprom_write_busy_i;
      eeb_s2 <= eeb_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          spm_ctrl_pkg::ADDR_CSR: wb_dat_o <= {24'h0, csr_view};
          spm_ctrl_pkg::ADDR_STATUS: begin
            wb_dat_o <= {30'h0, eeb_s2, state == BUSY};
          end
          default: wb_dat_o <= '0; // Unmapped reads zero
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= IDLE;
      cmd <= spm_ctrl_pkg::CSR_RESET[5:0];
      win <= '0;
      busy_cnt <= '0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_page_o <= '0;
      cpu_stall_o <= 1'b0;
    end else begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      case (state)
        IDLE: begin
          if (csr_wr && cmd_ok) begin
            state <= ARMED;
            cmd <= wr_cmd;
            win <= '0;
          end
        end
        ARMED: begin
          win <= win + 3'h1;
          if (store_hit && cmd == spm_ctrl_pkg::CMD_SIG) begin
            cmd <= cmd;
          end else if (store_hit && (cmd == spm_ctrl_pkg::CMD_ERASE ||
                       cmd == spm_ctrl_pkg::CMD_WRITE)) begin
            // Page from upper pointer bits
            flash_page_o <= pointer_i[WORD_BITS+PAGE_BITS:WORD_BITS+1];
            flash_erase_o <= (cmd == spm_ctrl_pkg::CMD_ERASE);
            flash_write_o <= (cmd == spm_ctrl_pkg::CMD_WRITE);
            cpu_stall_o <= 1'b1;
            busy_cnt <= '0;
            state <= BUSY;
          end else if (store_hit) begin
            state <= IDLE;
            cmd <= '0;
          end else if (load_hit && (cmd == spm_ctrl_pkg::CMD_SIG ||
                       cmd == spm_ctrl_pkg::CMD_FUSE)) begin
            state <= IDLE;
            cmd <= '0;
          end else if ((cmd == spm_ctrl_pkg::CMD_SIG &&
                        win >= spm_ctrl_pkg::LOAD_WINDOW - 3'h1) ||
                       win >= spm_ctrl_pkg::STORE_WINDOW - 3'h1) begin
            state <= IDLE;
            cmd <= '0;
          end
        end
        BUSY: begin
          // Timed erase or write, enable held
          if (busy_cnt == PROG_CYCLES - 1) begin
            state <= IDLE;
            cmd <= '0;
            cpu_stall_o <= 1'b0;
          end else begin
            busy_cnt <= busy_cnt + 32'h1;
          end
        end
        default: begin
          state <= IDLE;
          cmd <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temporary page buffer
  logic fill_hit, buf_clear;
  logic [WORD_BITS-1:0] widx;
  // Word index ignores pointer bit zero
  assign widx = pointer_i[WORD_BITS:1];
  assign fill_hit = store_hit && cmd == spm_ctrl_pkg::CMD_FILL;
  assign buf_clear = (csr_wr && cmd_ok && state == IDLE &&
                      wr_cmd == spm_ctrl_pkg::CMD_CLEAR) ||
                     (state == BUSY && cmd == spm_ctrl_pkg::CMD_WRITE &&
                      busy_cnt == PROG_CYCLES - 1) ||
                     eeb_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_valid <= '0;
    end else if (buf_clear) begin
      buf_valid <= '0;
    end else if (fill_hit && !buf_valid[widx]) begin
      buf_valid[widx] <= 1'b1;
    end
  end
  // Buffer storage, written once per word
  always_ff @(posedge clk_i) begin
    if (fill_hit && !buf_valid[widx]) begin
      buf_mem[widx] <= data_pair_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_data_o <= '0;
      load_valid_o <= 1'b0;
    end else begin
      load_valid_o <= load_strobe_i;
      if (load_hit && cmd == spm_ctrl_pkg::CMD_SIG) begin
        case (pointer_i)
          spm_ctrl_pkg::PTR_SIG0: load_data_o <= SIG_BYTE0;
          spm_ctrl_pkg::PTR_OSC_CAL: load_data_o <= OSC_CAL;
          spm_ctrl_pkg::PTR_SIG1: load_data_o <= SIG_BYTE1;
          spm_ctrl_pkg::PTR_SIG2: load_data_o <= SIG_BYTE2;
          spm_ctrl_pkg::PTR_TS_OFF: load_data_o <= TS_OFFSET;
          spm_ctrl_pkg::PTR_TS_GAIN: load_data_o <= TS_GAIN;
          default: load_data_o <= spm_ctrl_pkg::ERASED_BYTE;
        endcase
      end else if (load_hit && cmd == spm_ctrl_pkg::CMD_FUSE) begin
        // Inputs already active-low programmed
        case (pointer_i)
          spm_ctrl_pkg::PTR_FUSE_LOW: load_data_o <= fuse_low_byte_i;
          spm_ctrl_pkg::PTR_LOCK: begin
            load_data_o <= lock_bits_i & spm_ctrl_pkg::LOCK_MASK;
          end
          spm_ctrl_pkg::PTR_FUSE_EXT: begin
            load_data_o <= fuse_extended_byte_i & spm_ctrl_pkg::EXT_MASK;
          end
          spm_ctrl_pkg::PTR_FUSE_HIGH: load_data_o <= fuse_high_byte_i;
          default: load_data_o <= spm_ctrl_pkg::ERASED_BYTE;
        endcase
      end else if (load_strobe_i) begin
        // Byte select by pointer bit zero
        load_data_o <= pointer_i[0] ? flash_word_i[15:8]
                                    : flash_word_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(!wb_we_i && wb_adr_i == spm_ctrl_pkg::ADDR_CSR)
      |-> wb_dat_o[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved control bits not zero");

  property p_illegal_ignored;
    @(posedge clk_i) disable iff (rst_i)
      csr_wr && state == IDLE && !legal_cmd(wr_cmd) |=> state == IDLE;
  endproperty
  a_illegal_ignored: assert property (p_illegal_ignored)
    else $error("Illegal pattern armed a command");

  property p_store_timeout;
    @(posedge clk_i) disable iff (rst_i)
      csr_wr && cmd_ok && state == IDLE && wr_cmd != spm_ctrl_pkg::CMD_SIG
      ##1 (!store_strobe_i && !load_strobe_i) [*4] |=> state == IDLE;
  endproperty
  a_store_timeout: assert property (p_store_timeout)
    else $error("Store window did not close after four cycles");

  property p_sig_timeout;
    @(posedge clk_i) disable iff (rst_i)
      csr_wr && cmd_ok && state == IDLE && wr_cmd == spm_ctrl_pkg::CMD_SIG
      ##1 !load_strobe_i [*3] |=> state == IDLE;
  endproperty
  a_sig_timeout: assert property (p_sig_timeout)
    else $error("Signature window did not close after three cycles");

  property p_sig_store_none;
    @(posedge clk_i) disable iff (rst_i)
      store_hit && cmd == spm_ctrl_pkg::CMD_SIG
      |=> !flash_erase_o && !flash_write_o && $stable(buf_valid);
  endproperty
  a_sig_store_none: assert property (p_sig_store_none)
    else $error("Store after signature arm had an effect");

  property p_erase_stall;
    @(posedge clk_i) disable iff (rst_i)
      store_hit && cmd == spm_ctrl_pkg::CMD_ERASE
      |=> flash_erase_o && cpu_stall_o && cmd[spm_ctrl_pkg::BIT_EN];
  endproperty
  a_erase_stall: assert property (p_erase_stall)
    else $error("Erase did not start with stall");

  property p_eeprom_block;
    @(posedge clk_i) disable iff (rst_i)
      eeb_s2 && state == IDLE |=> state == IDLE;
  endproperty
  a_eeprom_block: assert property (p_eeprom_block)
    else $error("Command armed during EEPROM write");

  property p_clear_buffer;
    @(posedge clk_i) disable iff (rst_i)
      csr_wr && cmd_ok && state == IDLE && wr_cmd == spm_ctrl_pkg::CMD_CLEAR
      |=> buf_valid == '0;
  endproperty
  a_clear_buffer: assert property (p_clear_buffer)
    else $error("Page buffer not cleared");

  property p_lock_read;
    @(posedge clk_i) disable iff (rst_i)
      load_hit && cmd == spm_ctrl_pkg::CMD_FUSE &&
      pointer_i == spm_ctrl_pkg::PTR_LOCK
      |=> load_data_o == ($past(lock_bits_i) & spm_ctrl_pkg::LOCK_MASK);
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("Lock read returned wrong value");

  // Page write starts with the CPU held and enable kept
  property p_write_stall;
    @(posedge clk_i) disable iff (rst_i)
      store_hit && cmd == spm_ctrl_pkg::CMD_WRITE
      |=> flash_write_o && cpu_stall_o && cmd[spm_ctrl_pkg::BIT_EN];
  endproperty
  a_write_stall: assert property (p_write_stall)
    else $error("Write did not start with stall");

  // Whole timed operation keeps stall and enable up
  property p_busy_hold;
    @(posedge clk_i) disable iff (rst_i)
      state == BUSY |-> cpu_stall_o && cmd[spm_ctrl_pkg::BIT_EN];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("Stall or enable dropped during operation");

  // Timer end releases the CPU and clears the command bits
  property p_busy_done;
    @(posedge clk_i) disable iff (rst_i)
      state == BUSY && busy_cnt == PROG_CYCLES - 1
      |=> state == IDLE && !cpu_stall_o && cmd == '0;
  endproperty
  a_busy_done: assert property (p_busy_done)
    else $error("Operation end did not release stall and command");

  // Fuse or signature read disarms after its load
  property p_read_done;
    @(posedge clk_i) disable iff (rst_i)
      load_hit && (cmd == spm_ctrl_pkg::CMD_SIG ||
                   cmd == spm_ctrl_pkg::CMD_FUSE)
      |=> state == IDLE && cmd == '0;
  endproperty
  a_read_done: assert property (p_read_done)
    else $error("Read command did not clear after its load");

  // Finished page write empties the temporary buffer
  property p_write_clears_buffer;
    @(posedge clk_i) disable iff (rst_i)
      state == BUSY && cmd == spm_ctrl_pkg::CMD_WRITE &&
      busy_cnt == PROG_CYCLES - 1 |=> buf_valid == '0;
  endproperty
  a_write_clears_buffer: assert property (p_write_clears_buffer)
    else $error("Page buffer not cleared after write");

  c_fill: cover property (@(posedge clk_i) fill_hit);
  c_erase: cover property (@(posedge clk_i) flash_erase_o);
  c_write: cover property (@(posedge clk_i) flash_write_o);
  c_sig: cover property (@(posedge clk_i)
    load_hit && cmd == spm_ctrl_pkg::CMD_SIG);
  c_fuse: cover property (@(posedge clk_i)
    load_hit && cmd == spm_ctrl_pkg::CMD_FUSE);

endmodule // self_program_flash_control

// >>> core/spm_ctrl_pkg.sv
// Package with constants for the self-programming flash control unit
// Summary of operation
// - Store address from pointer: page, word
// - Load reads use pointer bit zero byte
// - Bits 7 and 6 read zero
// - Signature arm: next load returns signature
// - Store after signature arm does nothing
// - Clear-buffer command discards page buffer
// - Fuse arm: load returns lock or fuse
// - Page write arm: store programs page
// - Page erase arm: store erases page
// - Write/erase bits clear on done, timeout
// - CPU stalled during erase or write
// - Enable only: store fills buffer word
// - Enable clears after store or timeout
// - Only six patterns take effect
// - EEPROM write blocks programming, fuse reads
// - Pointer one returns two lock bits
// - Fuse arm clears on read or timeout
// - Pointers zero, three, two give fuses
// - Programmed bits read zero
// - Signature map of identity, calibration, sensor
// - Signature arm clears on read, timeout
// - Buffer erased after write and reset
// - Erase/write take 3.7 to 4.5 ms
package spm_ctrl_pkg;
  // Register map (byte addresses)
  localparam logic [3:0] ADDR_CSR = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // Control register bit positions
  localparam int BIT_EN = 0;
  localparam int BIT_ERS = 1;
  localparam int BIT_WRT = 2;
  localparam int BIT_FUSE = 3;
  localparam int BIT_CLR = 4;
  localparam int BIT_SIG = 5;
  // Accepted command patterns in lower six bits
  localparam logic [5:0] CMD_FILL = 6'h01;
  localparam logic [5:0] CMD_ERASE = 6'h03;
  localparam logic [5:0] CMD_WRITE = 6'h05;
  localparam logic [5:0] CMD_FUSE = 6'h09;
  localparam logic [5:0] CMD_CLEAR = 6'h11;
  localparam logic [5:0] CMD_SIG = 6'h21;
  localparam logic [7:0] CSR_RESET = 8'h00;
  // Arming windows in cycles
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  // Flash timing
  localparam int CLK_HZ = 25000000;
  localparam int PROG_TIME_US = 4100; // Between 3.7 ms and 4.5 ms
  localparam int PROG_CYCLES = CLK_HZ / 1000000 * PROG_TIME_US;
  // Pointer decodes for fuse/lock reads
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  // Pointer decodes for signature row
  localparam logic [15:0] PTR_SIG0 = 16'h0000;
  localparam logic [15:0] PTR_OSC_CAL = 16'h0001;
  localparam logic [15:0] PTR_SIG1 = 16'h0002;
  localparam logic [15:0] PTR_SIG2 = 16'h0004;
  localparam logic [15:0] PTR_TS_OFF = 16'h0005;
  localparam logic [15:0] PTR_TS_GAIN = 16'h0007;
  localparam logic [7:0] LOCK_MASK = 8'h03;
  localparam logic [7:0] EXT_MASK = 8'h01;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage
